// [design/ccp_coil.sv]
`timescale 1ns/1ns
module ccp_coil #(
  parameter int CNT_W = ccp_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic mode_sel,
  input wire logic trip,
  input wire logic [CNT_W-1:0] slow_cyc,
  input wire logic [CNT_W-1:0] blank_cyc,
  input wire logic [CNT_W-1:0] fast_cyc,
  output logic [1:0] bridge,
  output logic blanking
);
  ccp_pkg::ccp_state_t state_reg;
  ccp_pkg::ccp_state_t state_next;
  logic [CNT_W-1:0] phase_cnt_reg;
  logic [CNT_W-1:0] blank_cnt_reg;
  logic trip_ok;
  logic phase_done;

  // blank counter restarts on every phase change except a change into idle
  assign trip_ok = trip && (blank_cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    phase_done = 1'b0;
    unique case (state_reg)
      ccp_pkg::CCP_ST_IDLE: begin
        state_next = ccp_pkg::CCP_ST_ON;
      end
      ccp_pkg::CCP_ST_ON: begin
        if (trip_ok) begin
          phase_done = 1'b1;
          state_next = (mode_sel == ccp_pkg::MODE_CONST_OFF) ? ccp_pkg::CCP_ST_FAST
                                                           : ccp_pkg::CCP_ST_SLOW1;
        end
      end
      ccp_pkg::CCP_ST_SLOW1: begin
        if (phase_cnt_reg >= slow_cyc - 10'h001) begin
          phase_done = 1'b1;
          state_next = (mode_sel == ccp_pkg::MODE_CONST_OFF) ? ccp_pkg::CCP_ST_ON
                                                           : ccp_pkg::CCP_ST_FAST;
        end
      end
      ccp_pkg::CCP_ST_FAST: begin
        if (trip_ok || phase_cnt_reg >= fast_cyc - 10'h001) begin
          phase_done = 1'b1;
          state_next = (mode_sel == ccp_pkg::MODE_CONST_OFF) ? ccp_pkg::CCP_ST_SLOW1
                                                           : ccp_pkg::CCP_ST_SLOW2;
        end
      end
      ccp_pkg::CCP_ST_SLOW2: begin
        if (phase_cnt_reg >= slow_cyc - 10'h001) begin
          phase_done = 1'b1;
          state_next = ccp_pkg::CCP_ST_ON;
        end
      end
      default: state_next = ccp_pkg::CCP_ST_IDLE;
    endcase
    if (!run) begin
      state_next = ccp_pkg::CCP_ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ccp_pkg::CCP_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      phase_cnt_reg <= '0;
    end else if (phase_cnt_reg != '1) begin
      phase_cnt_reg <= phase_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_cnt_reg <= '0;
    end else if (state_next != state_reg && state_next != ccp_pkg::CCP_ST_IDLE) begin
      // full count so the mask and the blanking flag both last blank_cyc cycles
      blank_cnt_reg <= blank_cyc;
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_reg <= blank_cnt_reg - 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge <= ccp_pkg::BRIDGE_OFF;
      blanking <= 1'b0;
    end else begin
      blanking <= (state_next != state_reg && state_next != ccp_pkg::CCP_ST_IDLE)
                  || (blank_cnt_reg > 10'h001);
      unique case (state_next)
        ccp_pkg::CCP_ST_ON: bridge <= ccp_pkg::BRIDGE_ON;
        ccp_pkg::CCP_ST_FAST: bridge <= ccp_pkg::BRIDGE_FAST;
        ccp_pkg::CCP_ST_SLOW1, ccp_pkg::CCP_ST_SLOW2: bridge <= ccp_pkg::BRIDGE_SLOW;
        default: bridge <= ccp_pkg::BRIDGE_OFF;
      endcase
    end
  end

  chk_on_end_trip: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ccp_pkg::CCP_ST_ON && run && state_next != ccp_pkg::CCP_ST_ON) |-> trip_ok)
    else $error("on phase left without comparator trip");
  chk_blank_masks: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ccp_pkg::CCP_ST_ON && blank_cnt_reg != '0 && run) |=> (state_reg == ccp_pkg::CCP_ST_ON))
    else $error("trip honoured during blanking");
  chk_slow_timer: assert property (@(posedge clk) disable iff (rst)
    (state_reg inside {ccp_pkg::CCP_ST_SLOW1, ccp_pkg::CCP_ST_SLOW2} && run
     && phase_cnt_reg < slow_cyc - 10'h001) |=> (state_reg == $past(state_reg)))
    else $error("slow decay ended before timer");
  chk_four_order: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ccp_pkg::CCP_ST_SLOW1 && state_next != state_reg && run
     && mode_sel == ccp_pkg::MODE_FOUR_PHASE) |=> (state_reg == ccp_pkg::CCP_ST_FAST))
    else $error("four phase order broken");
  chk_three_order: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ccp_pkg::CCP_ST_ON && state_next != state_reg && run
     && mode_sel == ccp_pkg::MODE_CONST_OFF) |=> (state_reg == ccp_pkg::CCP_ST_FAST))
    else $error("constant off time order broken");
  chk_fast_bound: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ccp_pkg::CCP_ST_FAST && run && phase_cnt_reg >= fast_cyc - 10'h001)
    |=> (state_reg != ccp_pkg::CCP_ST_FAST || !$past(run)))
    else $error("fast decay outlived its timer");
  chk_blank_load: assert property (@(posedge clk) disable iff (rst)
    (state_next != state_reg && state_next != ccp_pkg::CCP_ST_IDLE)
    |=> (blank_cnt_reg == $past(blank_cyc)))
    else $error("blank counter not restarted on switch");
endmodule

// [design/ccp_pkg.sv]
package ccp_pkg;
  localparam int OFF_TIME_W = 4;
  localparam int BLANK_SEL_W = 2;
  localparam int SCALE_W = 8;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] SLOW_BASE_CYC = 10'h00c;
  localparam int SLOW_STEP_SHIFT = 5;
  localparam logic [CNT_W-1:0] BLANK_CYC_0 = 10'h010;
  localparam logic [CNT_W-1:0] BLANK_CYC_1 = 10'h018;
  localparam logic [CNT_W-1:0] BLANK_CYC_2 = 10'h024;
  localparam logic [CNT_W-1:0] BLANK_CYC_3 = 10'h036;
  localparam logic [CNT_W-1:0] FAST_CYC_DEFAULT = 10'h040;
  localparam logic [1:0] STANDSTILL_NORMAL = 2'h0;
  localparam logic [1:0] STANDSTILL_FREE = 2'h1;
  localparam logic [1:0] STANDSTILL_SHORT_LS = 2'h2;
  localparam logic [1:0] STANDSTILL_SHORT_HS = 2'h3;
  localparam logic [1:0] BRIDGE_OFF = 2'h0;
  localparam logic [1:0] BRIDGE_ON = 2'h1;
  localparam logic [1:0] BRIDGE_SLOW = 2'h2;
  localparam logic [1:0] BRIDGE_FAST = 2'h3;
  localparam logic MODE_FOUR_PHASE = 1'b0;
  localparam logic MODE_CONST_OFF = 1'b1;
  localparam logic [SCALE_W-1:0] SCALE_RESET = 8'h00;
  typedef enum logic [4:0] {
    CCP_ST_IDLE = 5'b00001,
    CCP_ST_ON = 5'b00010,
    CCP_ST_SLOW1 = 5'b00100,
    CCP_ST_FAST = 5'b01000,
    CCP_ST_SLOW2 = 5'b10000
  } ccp_state_t;
endpackage

// [design/ccp_sync.sv]
`timescale 1ns/1ns
module ccp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // change taken only once second and third stage agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule

// [design/ccp_top.sv]
`timescale 1ns/1ns
// Functional notes
// - standstill option picks normal, standstill_option, or short
// - read-only PWM scaling, frozen while the four-phase chopper runs
// - read-only tuned gradient and offset monitors
// - off time zero disables driver, else enabled
// - blank select gives 16/24/36/54 cycles
// - two coil choppers run independently
// - slow decay ends by timer only
// - on phase ends at comparator trip
// - fast decay ends at trip or timer
// - comparator masked for blank time after switching
// - constant off time: on, fast, slow
// - four-phase: on, slow, fast, slow
// - mode bit 0 four-phase, 1 constant off
// - slow decay cycles are 12 plus 32*setting
// - global enable permits voltage-mode PWM operation
module ccp_top #(
  parameter int NCOIL = 2,
  parameter int CNT_W = ccp_pkg::CNT_W,
  parameter logic [ccp_pkg::CNT_W-1:0] FAST_CYC = ccp_pkg::FAST_CYC_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [ccp_pkg::OFF_TIME_W-1:0] OFF_TIME_SETTING,
  input wire logic [ccp_pkg::BLANK_SEL_W-1:0] BLANK_TIME_SELECT,
  input wire logic CHOPPER_MODE,
  input wire logic PWM_ENABLE,
  input wire logic PWM_VELOCITY_OK,
  input wire logic HOLD_ZERO,
  input wire logic [1:0] STANDSTILL_OPTION,
  input wire logic [NCOIL-1:0] CMP_TRIP,
  input wire logic [ccp_pkg::SCALE_W-1:0] SCALE_IN,
  input wire logic [ccp_pkg::SCALE_W-1:0] GRAD_IN,
  input wire logic [ccp_pkg::SCALE_W-1:0] OFS_IN,
  output logic [2*NCOIL-1:0] BRIDGE_CTRL,
  output logic [NCOIL-1:0] BLANKING,
  output logic DRIVER_ENABLE,
  output logic PWM_ACTIVE,
  output logic [1:0] STANDSTILL_STATE,
  output logic [ccp_pkg::SCALE_W-1:0] PWM_SCALE_READBACK,
  output logic [ccp_pkg::SCALE_W-1:0] TUNED_GRADIENT_READBACK,
  output logic [ccp_pkg::SCALE_W-1:0] TUNED_OFFSET_READBACK
);
  logic [CNT_W-1:0] slow_cyc;
  logic [CNT_W-1:0] blank_cyc;
  logic drv_on;
  logic pwm_mode;
  logic chop_run;
  logic [NCOIL-1:0] trip_sync;

  assign drv_on = (OFF_TIME_SETTING != '0);
  assign pwm_mode = PWM_ENABLE && PWM_VELOCITY_OK;
  // voltage mode needs no cycle chopper; off time value only gates enable there
  assign chop_run = drv_on && !pwm_mode;
  assign slow_cyc = ccp_pkg::SLOW_BASE_CYC
                    + (CNT_W'(OFF_TIME_SETTING) << ccp_pkg::SLOW_STEP_SHIFT);

  always_comb begin
    unique case (BLANK_TIME_SELECT)
      2'h0: blank_cyc = ccp_pkg::BLANK_CYC_0;
      2'h1: blank_cyc = ccp_pkg::BLANK_CYC_1;
      2'h2: blank_cyc = ccp_pkg::BLANK_CYC_2;
      2'h3: blank_cyc = ccp_pkg::BLANK_CYC_3;
    endcase
  end

  // one chopper per coil, sharing settings only
  genvar gi;
  generate
    for (gi = 0; gi < NCOIL; gi++) begin : g_coil
      logic [1:0] br;
      ccp_sync u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .din(CMP_TRIP[gi]),
        .dout(trip_sync[gi])
      );
      ccp_coil #(.CNT_W(CNT_W)) u_coil (
        .clk(SYS_CLK),
        .rst(RESET),
        .run(chop_run),
        .mode_sel(CHOPPER_MODE),
        .trip(trip_sync[gi]),
        .slow_cyc(slow_cyc),
        .blank_cyc(blank_cyc),
        .fast_cyc(FAST_CYC),
        .bridge(br),
        .blanking(BLANKING[gi])
      );
      assign BRIDGE_CTRL[2*gi+1:2*gi] = br;
    end
  endgenerate

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      DRIVER_ENABLE <= 1'b0;
      PWM_ACTIVE <= 1'b0;
    end else begin
      DRIVER_ENABLE <= drv_on;
      PWM_ACTIVE <= drv_on && pwm_mode;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      STANDSTILL_STATE <= ccp_pkg::STANDSTILL_NORMAL;
    end else if (HOLD_ZERO && pwm_mode) begin
      STANDSTILL_STATE <= STANDSTILL_OPTION;
    end else begin
      STANDSTILL_STATE <= ccp_pkg::STANDSTILL_NORMAL;
    end
  end

  // scaling holds its last value while the chopper runs in four-phase mode
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PWM_SCALE_READBACK <= ccp_pkg::SCALE_RESET;
    end else if (!(CHOPPER_MODE == ccp_pkg::MODE_FOUR_PHASE && chop_run)) begin
      PWM_SCALE_READBACK <= SCALE_IN;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      TUNED_GRADIENT_READBACK <= ccp_pkg::SCALE_RESET;
      TUNED_OFFSET_READBACK <= ccp_pkg::SCALE_RESET;
    end else begin
      TUNED_GRADIENT_READBACK <= GRAD_IN;
      TUNED_OFFSET_READBACK <= OFS_IN;
    end
  end

  chk_scale_frozen: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (CHOPPER_MODE == ccp_pkg::MODE_FOUR_PHASE && chop_run) |=> $stable(PWM_SCALE_READBACK))
    else $error("scaling changed while chopper active");
  chk_driver_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (OFF_TIME_SETTING == '0) |=> (!DRIVER_ENABLE && BRIDGE_CTRL == '0))
    else $error("driver on with zero off time");
  chk_standstill: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (HOLD_ZERO && pwm_mode) |=> (STANDSTILL_STATE == $past(STANDSTILL_OPTION)))
    else $error("standstill option not applied");
endmodule

// [testbench/ccp_bridge_model.sv]
`timescale 1ns/1ns
module ccp_bridge_model #(
  parameter int NCOIL = 2
) (
  input wire logic clk,
  input wire logic [2*NCOIL-1:0] bridge_ctrl,
  input wire logic [8*NCOIL-1:0] trip_delay,
  input wire logic fast_trip_en,
  output logic [NCOIL-1:0] cmp_trip
);
  logic [1:0] prev [NCOIL];
  logic [9:0] age [NCOIL];
  // age of the present bridge phase, restarted at every switching event
  always @(posedge clk) begin
    for (int i = 0; i < NCOIL; i++) begin
      age[i] <= (bridge_ctrl[2*i+:2] !== prev[i]) ? 10'h000 : age[i] + 10'h001;
      prev[i] <= bridge_ctrl[2*i+:2];
    end
  end
  always_comb begin
    for (int i = 0; i < NCOIL; i++) begin
      cmp_trip[i] = 1'b0;
      if (bridge_ctrl[2*i+:2] == ccp_pkg::BRIDGE_SLOW) begin
        // no sense current in slow decay, so the comparator output is junk
        cmp_trip[i] = age[i][0];
      end else if (bridge_ctrl[2*i+:2] == ccp_pkg::BRIDGE_ON ||
                   (bridge_ctrl[2*i+:2] == ccp_pkg::BRIDGE_FAST && fast_trip_en)) begin
        // switching spikes first, then a clean trip at target current
        cmp_trip[i] = (age[i] < 10'h004) ? age[i][0] : (age[i] >= {2'h0, trip_delay[8*i+:8]});
      end
    end
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
  logic sys_clk, reset, chop_mode, pwm_en, vel_ok, hold_zero, fast_trip_en, mon_on;
  logic [3:0] off_time;
  logic [1:0] blank_sel, stand_opt;
  logic [7:0] scale_in, grad_in, ofs_in, scale_rb, grad_rb, ofs_rb;
  logic [15:0] trip_delay;
  logic [1:0] cmp_trip, blanking, stand_state;
  logic [3:0] bridge_ctrl;
  logic drv_en, pwm_act;
  logic [31:0] rnd;
  int miscompares, comparisons, nsw;
  int dur [2];
  int blk [2];
  logic [1:0] prv [2];
  logic [1:0] last_ns [2];
  bit armed [2];

  ccp_top dut (.SYS_CLK(sys_clk), .RESET(reset), .OFF_TIME_SETTING(off_time),
    .BLANK_TIME_SELECT(blank_sel), .CHOPPER_MODE(chop_mode), .PWM_ENABLE(pwm_en),
    .PWM_VELOCITY_OK(vel_ok), .HOLD_ZERO(hold_zero), .STANDSTILL_OPTION(stand_opt),
    .CMP_TRIP(cmp_trip), .SCALE_IN(scale_in), .GRAD_IN(grad_in), .OFS_IN(ofs_in),
    .BRIDGE_CTRL(bridge_ctrl), .BLANKING(blanking), .DRIVER_ENABLE(drv_en),
    .PWM_ACTIVE(pwm_act), .STANDSTILL_STATE(stand_state), .PWM_SCALE_READBACK(scale_rb),
    .TUNED_GRADIENT_READBACK(grad_rb), .TUNED_OFFSET_READBACK(ofs_rb));
  ccp_bridge_model #(.NCOIL(2)) partner (.clk(sys_clk), .bridge_ctrl(bridge_ctrl),
    .trip_delay(trip_delay), .fast_trip_en(fast_trip_en), .cmp_trip(cmp_trip));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int blank_len(logic [1:0] s);
    return (s == 2'h0) ? 16 : (s == 2'h1) ? 24 : (s == 2'h2) ? 36 : 54;
  endfunction
  function automatic logic [1:0] next_phase(logic [1:0] p, logic [1:0] lns);
    if (chop_mode == ccp_pkg::MODE_CONST_OFF) begin
      return (p == ccp_pkg::BRIDGE_ON) ? ccp_pkg::BRIDGE_FAST :
             (p == ccp_pkg::BRIDGE_FAST) ? ccp_pkg::BRIDGE_SLOW : ccp_pkg::BRIDGE_ON;
    end
    if (p != ccp_pkg::BRIDGE_SLOW) return ccp_pkg::BRIDGE_SLOW;
    return (lns == ccp_pkg::BRIDGE_ON) ? ccp_pkg::BRIDGE_FAST : ccp_pkg::BRIDGE_ON;
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic check_phase(int i, logic [1:0] p, logic [1:0] c);
    int lo, bl;
    bl = blank_len(blank_sel);
    lo = (trip_delay[8*i+:8] > bl) ? int'(trip_delay[8*i+:8]) : bl;
    chk("phase order", c, next_phase(p, last_ns[i]));
    if (p == ccp_pkg::BRIDGE_SLOW) begin
      chk("slow length", dur[i], 12 + 32 * off_time);
    end else begin
      chk("blank length", blk[i], bl);
      if (p == ccp_pkg::BRIDGE_ON || fast_trip_en) begin
        chk("trip end", dur[i] >= lo && dur[i] <= lo + 8, 1);
      end else begin
        chk("fast timer", dur[i], int'(ccp_pkg::FAST_CYC_DEFAULT));
      end
    end
  endtask

  always @(negedge sys_clk) begin
    logic [1:0] cur;
    for (int i = 0; i < 2; i++) begin
      cur = bridge_ctrl[2*i+:2];
      if (!mon_on) begin
        armed[i] = 0;
        prv[i] = cur;
      end else if (cur != prv[i]) begin
        if (armed[i]) check_phase(i, prv[i], cur);
        if (prv[i] != ccp_pkg::BRIDGE_SLOW) last_ns[i] = prv[i];
        armed[i] = (prv[i] != ccp_pkg::BRIDGE_OFF);
        if (i == 0) nsw++;
        prv[i] = cur;
        dur[i] = 1;
        blk[i] = blanking[i];
      end else begin
        dur[i]++;
        blk[i] += blanking[i];
      end
    end
  end

  task automatic cycles(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chop_run(logic m, logic [1:0] bs);
    int t;
    rnd = lfsr(rnd);
    chop_mode = m;
    blank_sel = bs;
    fast_trip_en = rnd[20];
    trip_delay = rnd[15:0] & 16'h3f3f;
    mon_on = 1;
    nsw = 0;
    off_time = 4'h1 + {2'h0, rnd[17:16] & 2'h1};
    for (t = 0; t < 3000 && nsw < 12; t++) cycles(1);
    if (t == 3000) begin
      miscompares++;
      give_verdict();
    end
    mon_on = 0;
    off_time = 4'h0;
    cycles(6);
  endtask

  initial begin
    {chop_mode, pwm_en, vel_ok, hold_zero, fast_trip_en, mon_on} = '0;
    {off_time, blank_sel, stand_opt, scale_in, grad_in, ofs_in, trip_delay} = '0;
    rnd = 32'hde06;
    reset = 1'b1;
    cycles(10);
    chk("reset outputs", {bridge_ctrl, blanking, drv_en, pwm_act, stand_state, scale_rb,
      grad_rb}, 0);
    chk("reset offset", ofs_rb, 0);
    reset = 1'b0;
    cycles(2);
    chk("driver off", drv_en, 0);
    for (int k = 0; k < 32; k++) begin
      rnd = lfsr(rnd);
      {hold_zero, vel_ok, pwm_en, stand_opt} = k[4:0];
      chop_mode = ccp_pkg::MODE_CONST_OFF;
      off_time = rnd[3:0] | 4'h1;
      {scale_in, grad_in, ofs_in} = rnd[31:8];
      cycles(4);
      chk("driver on", drv_en, 1);
      chk("pwm active", pwm_act, pwm_en & vel_ok);
      if (pwm_en & vel_ok) chk("no chopping", bridge_ctrl, 0);
      chk("standstill", stand_state, (hold_zero & pwm_en & vel_ok) ? stand_opt : 2'h0);
      chk("gradient", grad_rb, grad_in);
      chk("offset", ofs_rb, ofs_in);
      chk("scale follow", scale_rb, scale_in);
    end
    $display("test settings done");
    {pwm_en, vel_ok, off_time} = '0;
    cycles(4);
    for (int j = 0; j < 16; j++) chop_run(j[0], j[2:1]);
    $display("test chopping done");
    scale_in = 8'h5a;
    cycles(3);
    chop_mode = ccp_pkg::MODE_FOUR_PHASE;
    off_time = 4'h2;
    cycles(6);
    scale_in = 8'ha5;
    cycles(4);
    chk("scale frozen", scale_rb, 8'h5a);
    chop_mode = ccp_pkg::MODE_CONST_OFF;
    cycles(4);
    chk("scale thaw", scale_rb, 8'ha5);
    $display("test freeze done");
    give_verdict();
  end
endmodule
